/* File: core/afb_pkg.sv */
package afb_pkg;
    localparam int CLK_PERIOD_PS = 5000;
    // read and write timings per speed grade, in ns; the shared and reset times below are in ns, busy ready in us
    localparam int T_RC_NS_G0 = 55;
    localparam int T_RC_NS_G1 = 70;
    localparam int T_RC_NS_G2 = 90;
    localparam int T_OE_NS_G0 = 30;
    localparam int T_OE_NS_G1 = 30;
    localparam int T_OE_NS_G2 = 35;
    localparam int T_WP_NS_G0 = 30;
    localparam int T_WP_NS_G1 = 35;
    localparam int T_WP_NS_G2 = 45;
    localparam int T_WPH_NS = 20;
    localparam int T_OEH_POLL_NS = 10;
    localparam int T_RH_NS = 50;
    localparam int T_RP_NS = 500;
    localparam int T_READY_IDLE_NS = 500;
    localparam int T_READY_BUSY_US = 20;
    // least times round up, counts at least one cycle
    function automatic int cyc_min(input int ns);
        int c;
        c = (ns * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
        return (c < 1) ? 1 : c;
    endfunction
    localparam int RC_CYC_G2 = cyc_min(T_RC_NS_G2);
    localparam int OE_CYC_G2 = cyc_min(T_OE_NS_G2);
    localparam int WP_CYC_G2 = cyc_min(T_WP_NS_G2);
    localparam int WPH_CYC = cyc_min(T_WPH_NS);
    localparam int OEH_POLL_CYC = cyc_min(T_OEH_POLL_NS);
    localparam int RH_CYC = cyc_min(T_RH_NS);
    localparam int RP_CYC = cyc_min(T_RP_NS);
    localparam int READY_IDLE_CYC = cyc_min(T_READY_IDLE_NS);
    localparam int READY_BUSY_CYC = cyc_min(T_READY_BUSY_US * 1000);
    localparam int CNT_W = 13;
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_RST = 3'b001,
        ST_RREC = 3'b011,
        ST_RD = 3'b010,
        ST_WR = 3'b110,
        ST_GAP = 3'b111
    } afb_state_e;
endpackage

/* File: core/afb_host.sv */
`timescale 1ns/1ps
`default_nettype none
module afb_host #(
    parameter int ADDR_W = 18,
    parameter int RC_CYC = afb_pkg::RC_CYC_G2,
    parameter int OE_CYC = afb_pkg::OE_CYC_G2,
    parameter int WP_CYC = afb_pkg::WP_CYC_G2,
    parameter int READY_BUSY_CYC = afb_pkg::READY_BUSY_CYC
) (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_valid,
    output logic req_ready,
    input wire logic req_write,
    input wire logic req_poll,
    input wire logic [ADDR_W-1:0] req_addr,
    input wire logic [7:0] req_wdata,
    input wire logic reset_req,
    input wire logic reset_busy,
    output logic rsp_valid,
    output logic [7:0] rsp_rdata,
    output logic [ADDR_W-1:0] flash_addr,
    output logic flash_ce_n,
    output logic flash_oe_n,
    output logic flash_we_n,
    output logic flash_reset_n,
    input wire logic [7:0] flash_dq_i,
    output logic [7:0] flash_dq_o,
    output logic flash_dq_oe
);
    afb_pkg::afb_state_e st_q, st_d;
    logic [afb_pkg::CNT_W-1:0] cnt_q, cnt_d;
    logic [afb_pkg::CNT_W-1:0] rdy_q, rdy_d;
    logic poll_q, poll_d;
    logic wr_q, wr_d;
    logic busy_q, busy_d;
    logic [ADDR_W-1:0] addr_q, addr_d;
    logic [7:0] wdat_q, wdat_d, rdat_q, rdat_d;
    logic rv_q, rv_d;
    logic [7:0] dq_s1_q, dq_s2_q;
    // pin strobes, registered so that no decode glitch reaches the device
    logic ce_n_q, ce_n_d, oe_n_q, oe_n_d, we_n_q, we_n_d;
    logic rstn_q, rstn_d, dqoe_q, dqoe_d;

    // two stages on the data pins before anything samples them
    // the device drives them with no relation to this clock
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dq_s1_q <= 8'h00;
            dq_s2_q <= 8'h00;
        end else begin
            dq_s1_q <= flash_dq_i;
            dq_s2_q <= dq_s1_q;
        end
    end

    // sequencer for reset, read and write strobes
    // cnt_q times the phase in hand and the strobe-high time after a write;
    // rdy_q holds off new requests after a reset, so the device sees its recovery gaps
    // a reset request wins over a waiting transfer, but never cuts
    // a strobe already on the pins
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        rdy_d = rdy_q;
        poll_d = poll_q;
        wr_d = wr_q;
        busy_d = busy_q;
        addr_d = addr_q;
        wdat_d = wdat_q;
        rdat_d = rdat_q;
        rv_d = 1'b0;
        if (cnt_q != '0) cnt_d = cnt_q - 1'b1;
        if (rdy_q != '0) rdy_d = rdy_q - 1'b1;
        case (st_q)
            afb_pkg::ST_IDLE: begin
                // reset first; new work once both hold-off counts are out
                if (reset_req) begin
                    st_d = afb_pkg::ST_RST;
                    busy_d = reset_busy;
                    cnt_d = afb_pkg::CNT_W'(afb_pkg::RP_CYC);
                end else if (req_valid && cnt_q == '0 && rdy_q == '0) begin
                    addr_d = req_addr;
                    wdat_d = req_wdata;
                    wr_d = req_write;
                    poll_d = req_poll;
                    if (req_write) begin
                        st_d = afb_pkg::ST_WR;
                        cnt_d = afb_pkg::CNT_W'(RC_CYC);
                    end else begin
                        st_d = afb_pkg::ST_RD;
                        // two sync stages delay the sample; two extra
                        // cycles keep it after the access time
                        cnt_d = afb_pkg::CNT_W'(RC_CYC + 2);
                    end
                end
            end
            afb_pkg::ST_RST: begin
                if (cnt_q == '0) begin
                    st_d = afb_pkg::ST_RREC;
                    // busy device needs longer to abort
                    cnt_d = busy_q ? afb_pkg::CNT_W'(READY_BUSY_CYC)
                        : afb_pkg::CNT_W'(afb_pkg::READY_IDLE_CYC);
                end
            end
            afb_pkg::ST_RREC: begin
                if (cnt_q == '0) begin
                    st_d = afb_pkg::ST_IDLE;
                    // reset stays released a while before the first read
                    rdy_d = afb_pkg::CNT_W'(afb_pkg::RH_CYC);
                end
            end
            afb_pkg::ST_RD: begin
                // oe window long enough for both access paths
                if (cnt_q == '0) begin
                    rdat_d = dq_s2_q;
                    rv_d = 1'b1;
                    st_d = afb_pkg::ST_GAP;
                    // polling reads need oe high between strobes
                    cnt_d = poll_q ? afb_pkg::CNT_W'(afb_pkg::OEH_POLL_CYC)
                        : afb_pkg::CNT_W'(1);
                end
            end
            afb_pkg::ST_WR: begin
                // strobe low for the pulse width; the cycle ends in the gap
                if (cnt_q == afb_pkg::CNT_W'(RC_CYC - WP_CYC)) begin
                    st_d = afb_pkg::ST_GAP;
                end
            end
            afb_pkg::ST_GAP: begin
                // a write spends the rest of its cycle count here, then
                // the strobe-high time is added before the next request
                if (cnt_q == '0) begin
                    st_d = afb_pkg::ST_IDLE;
                    if (wr_q) cnt_d = afb_pkg::CNT_W'(afb_pkg::WPH_CYC);
                end
            end
            default: st_d = afb_pkg::ST_IDLE;
        endcase
    end

    // strobes follow the next state, one register from the pins;
    // decoding st_q directly could pass through a write or read code
    // while several state bits change, a spurious strobe at the device
    always_comb begin
        ce_n_d = !(st_d == afb_pkg::ST_RD || st_d == afb_pkg::ST_WR);
        oe_n_d = (st_d != afb_pkg::ST_RD);
        we_n_d = (st_d != afb_pkg::ST_WR);
        rstn_d = (st_d != afb_pkg::ST_RST);
        dqoe_d = (st_d == afb_pkg::ST_WR);
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ce_n_q <= 1'b1;
            oe_n_q <= 1'b1;
            we_n_q <= 1'b1;
            rstn_q <= 1'b1;
            dqoe_q <= 1'b0;
        end else begin
            ce_n_q <= ce_n_d;
            oe_n_q <= oe_n_d;
            we_n_q <= we_n_d;
            rstn_q <= rstn_d;
            dqoe_q <= dqoe_d;
        end
    end

    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            st_q <= afb_pkg::ST_IDLE;
            cnt_q <= '0;
            rdy_q <= afb_pkg::CNT_W'(afb_pkg::RH_CYC);
            poll_q <= 1'b0;
            wr_q <= 1'b0;
            busy_q <= 1'b0;
            addr_q <= '0;
            wdat_q <= 8'h00;
            rdat_q <= 8'h00;
            rv_q <= 1'b0;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            rdy_q <= rdy_d;
            poll_q <= poll_d;
            wr_q <= wr_d;
            busy_q <= busy_d;
            addr_q <= addr_d;
            wdat_q <= wdat_d;
            rdat_q <= rdat_d;
            rv_q <= rv_d;
        end
    end

    // pin drive; the request handshake is combinational,
    // every pin comes straight from a flip-flop
    assign req_ready = (st_q == afb_pkg::ST_IDLE) && !reset_req &&
        cnt_q == '0 && rdy_q == '0;
    assign rsp_valid = rv_q;
    assign rsp_rdata = rdat_q;
    assign flash_addr = addr_q;
    assign flash_reset_n = rstn_q;
    assign flash_ce_n = ce_n_q;
    assign flash_oe_n = oe_n_q;
    assign flash_we_n = we_n_q;
    assign flash_dq_o = wdat_q;
    assign flash_dq_oe = dqoe_q;
endmodule
`default_nettype wire

/* File: sim/afb_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
// behavioural flash; one write stands in for a whole program sequence
module afb_flash_model #(
    parameter int PROG_CYC = 1400,
    // erase time, one second scaled down to keep runs short
    parameter int ERASE_CYC = 3000,
    // marker data standing in for an erase sequence; value arbitrary
    parameter logic [7:0] ERASE_DATA = 8'hee
) (
    input wire logic clk_sys,
    input wire logic [17:0] flash_addr,
    input wire logic flash_ce_n,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_reset_n,
    input wire logic [7:0] flash_dq_o,
    output logic [7:0] flash_dq_i
);
    logic [7:0] mem [16];
    logic [7:0] stat = 8'h00, last = 8'h00;
    logic we_q = 1'b1, rd_q = 1'b0;
    int busy = 0;
    wire logic rd = !flash_ce_n && !flash_oe_n;
    // edges found against the previous host clock sample
    always @(posedge clk_sys) begin
        if (!flash_reset_n)
            busy <= 0;
        else if (busy > 0)
            busy <= busy - 1;
        if (flash_reset_n && !we_q && flash_we_n) begin
            if (flash_dq_o == ERASE_DATA) begin
                // the whole model array stands for one sector
                for (int i = 0; i < 16; i++)
                    mem[i] <= 8'hff;
                busy <= ERASE_CYC;
            end else begin
                mem[flash_addr[3:0]] <= flash_dq_o;
                busy <= PROG_CYC;
            end
        end
        // alternate bit stays: no sector is erase-suspended here
        if (rd && !rd_q && busy > 0)
            stat <= stat ^ 8'h40;
        if (rd)
            last <= flash_dq_i;
        we_q <= flash_we_n;
        rd_q <= rd;
    end
    // released bus shows the inverse, so a stale value cannot pass
    assign flash_dq_i = !rd ? ~last :
        (busy > 0 ? stat : mem[flash_addr[3:0]]);
endmodule
`default_nettype wire

/* File: sim/afb_host_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module afb_host_asserts (
    input wire logic clk_sys,
    input wire logic rst,
    input wire logic req_ready,
    input wire logic reset_busy,
    input wire logic rsp_valid,
    input wire logic flash_oe_n,
    input wire logic flash_we_n,
    input wire logic flash_reset_n,
    input wire logic flash_dq_oe
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    // strobe widths, gaps and answers, in 5 ns cycles
    a_wp_width: assert property ($fell(flash_we_n) |=> !flash_we_n [*8])
        else $error("write pulse");
    a_wph_gap: assert property ($rose(flash_we_n) |-> flash_we_n [*4])
        else $error("write gap");
    a_oe_width: assert property ($fell(flash_oe_n) |=> !flash_oe_n [*7])
        else $error("read pulse");
    a_oe_we_excl: assert property (flash_oe_n || flash_we_n)
        else $error("strobe clash");
    a_dq_drive: assert property (
        flash_dq_oe == !flash_we_n && (flash_oe_n || !flash_dq_oe))
        else $error("data drive");
    a_rsp_after: assert property ($rose(flash_oe_n) |-> ##[0:2] rsp_valid)
        else $error("no read answer");
    a_rp_width: assert property (
        $fell(flash_reset_n) |-> ##99 !flash_reset_n) else $error("reset");
    a_rh_hold: assert property (
        $rose(flash_reset_n) |-> flash_oe_n [*8]) else $error("early read");
    a_rdy_idle: assert property (
        $fell(flash_reset_n) && !reset_busy |-> ##[150:230] req_ready)
        else $error("late ready");
endmodule
bind afb_host afb_host_asserts u_chk (.*);
`default_nettype wire

/* File: sim/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, s) begin checks++; if ((s) !== (e)) begin err_count++; \
    $display("mismatch %s exp %h got %h", nm, e, s); end end
module tb;
    logic clk_sys = 0, rst = 1, req_valid = 0, req_write = 0, req_poll = 0;
    logic reset_req = 0, reset_busy = 0, req_ready, rsp_valid, flash_ce_n;
    logic flash_oe_n, flash_we_n, flash_reset_n, flash_dq_oe;
    logic [17:0] req_addr = '0, flash_addr;
    logic [7:0] req_wdata = '0, rsp_rdata, flash_dq_i, flash_dq_o, q0, q1;
    int err_count = 0, checks = 0;
    // busy recovery shortened to keep the run brief
    afb_host #(.READY_BUSY_CYC(50)) DUT (.*);
    afb_flash_model #(.ERASE_CYC(3000), .ERASE_DATA(8'hee)) u_flash (.*);
    always #2.5 clk_sys = ~clk_sys;
    task automatic stop_test;
        $display("checks %0d err_count %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    // request held until taken; a read also waits for its data
    task automatic xfer(input logic w, p, input logic [17:0] a,
                        input logic [7:0] d, output logic [7:0] q);
        @(negedge clk_sys);
        {req_valid, req_write, req_poll} = {1'b1, w, p};
        {req_addr, req_wdata} = {a, d};
        while (req_ready !== 1'b1) @(negedge clk_sys);
        @(negedge clk_sys);
        req_valid = 0;
        while (!w && rsp_valid !== 1'b1) @(negedge clk_sys);
        q = rsp_rdata;
    endtask
    task automatic t_prog;
        xfer(1, 0, 18'h5, 8'h3c, q0);
        xfer(0, 1, 18'h3, 8'h00, q0);
        xfer(0, 1, 18'h9, 8'h00, q1);
        `CHK("poll1", 8'h40, q0)
        `CHK("poll2", 8'h00, q1)
        repeat (1400) @(negedge clk_sys);
        xfer(0, 0, 18'h5, 8'h00, q0);
        `CHK("array", 8'h3c, q0)
    endtask
    // erase keeps the model busy far longer, then reads back blank
    task automatic t_erase;
        xfer(1, 0, 18'h5, 8'hee, q0);
        xfer(0, 1, 18'h2, 8'h00, q0);
        `CHK("erase busy", 8'h40, q0)
        repeat (3000) @(negedge clk_sys);
        xfer(0, 0, 18'h5, 8'h00, q0);
        `CHK("erased", 8'hff, q0)
    endtask
    // reset while busy or idle; stored data must read back after
    task automatic t_reset(input logic b, input logic [7:0] d,
                           input int lo, hi);
        int n;
        xfer(1, 0, 18'h6, d, q0);
        repeat (b ? 0 : 1500) @(negedge clk_sys);
        {reset_busy, reset_req} = {b, 1'b1};
        while (flash_reset_n !== 1'b0) @(negedge clk_sys);
        reset_req = 0;
        for (n = 0; req_ready !== 1'b1; n++) @(negedge clk_sys);
        `CHK("ready", 1'b1, n >= lo && n <= hi)
        xfer(0, 0, 18'h6, 8'h00, q0);
        `CHK("after", d, q0)
    endtask
    initial begin
        #40 rst = 0;
        t_prog;
        t_erase;
        // low end: reset pulse plus hold before a read; high end adds
        // the recovery wait and two state steps
        t_reset(1, 8'h5a, afb_pkg::RP_CYC + afb_pkg::RH_CYC,
                afb_pkg::RP_CYC + 50 + afb_pkg::RH_CYC + 2);
        t_reset(0, 8'ha5, afb_pkg::RP_CYC + afb_pkg::RH_CYC,
                afb_pkg::RP_CYC + afb_pkg::READY_IDLE_CYC +
                afb_pkg::RH_CYC + 2);
        stop_test;
    end
    // watchdog at about three times the expected run
    initial begin
        #100000 err_count++;
        stop_test;
    end
endmodule
`default_nettype wire
